// ===== hw/drs_pkg.sv
/*
  drs_pkg: constants, field positions and carrier types for the transfer
  register and status block.
  assumes: AHB-Lite slave with 32-bit data, word offsets scaled by four.
*/
package drs_pkg;

  // ==========================================================
  // register indices and byte addresses
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_RD_PTR = 3'h1;
  localparam logic [2:0] IDX_WR_PTR = 3'h2;
  localparam logic [2:0] IDX_COUNT = 3'h3;
  localparam logic [2:0] IDX_RSVD_A = 3'h4;
  localparam logic [2:0] IDX_RSVD_B = 3'h5;
  localparam logic [2:0] IDX_CONTROL = 3'h6;
  localparam logic [2:0] IDX_RSVD_C = 3'h7;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 3;

  // ==========================================================
  // status field positions
  localparam int ST_DONE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_RPEND = 2;
  localparam int ST_WPEND = 3;
  localparam int ST_CNTZ = 4;

  // ==========================================================
  // control field positions
  localparam int CT_START = 3;
  localparam int CT_IRQ_EN = 4;
  localparam int CT_RD_EOP_EN = 5;
  localparam int CT_WR_EOP_EN = 6;
  localparam int CT_END_ON_CNT = 7;
  localparam int CT_W = 13;

  // ==========================================================
  // reset values and constants
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] RSVD_READ = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // ==========================================================
  // engine states
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } drs_state_t;

  // ==========================================================
  // write beat, beat size and end-of-packet events from the data path
  typedef struct packed
  {
    logic wr_beat;
    logic [4:0] beat_bytes;
    logic rd_eop;
    logic wr_eop;
  } drs_evt_t;

  // latched ahb address phase
  typedef struct packed
  {
    logic valid;
    logic write;
    logic [2:0] idx;
  } drs_aphase_t;

endpackage

// ===== hw/drs_ahb_slave.sv
/*
  drs_ahb_slave: captures the AHB-Lite address phase and gives one-cycle
  read/write strobes in the data phase; always zero wait states, OKAY.
  assumes: single master, hready of the bus equals our hreadyout.
*/
module drs_ahb_slave
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // ahb address phase
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // data phase strobes
  output logic wr_stb,
  output logic rd_stb,
  output logic [2:0] idx
);

  // ==========================================================
  // state
  typedef struct packed
  {
    drs_pkg::drs_aphase_t ap;
  } drs_slv_state_t;

  drs_slv_state_t s_reg;
  drs_slv_state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    if (hready)
    begin
      s_next.ap.valid = hsel && (htrans == drs_pkg::HTRANS_NONSEQ ||
                                 htrans == drs_pkg::HTRANS_SEQ);
      s_next.ap.write = hwrite;
      s_next.ap.idx = haddr[drs_pkg::ADDR_LSB +: drs_pkg::IDX_W];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      s_reg <= '0;
    else if (ce)
      s_reg <= s_next;
  end

  // zero wait states, so every data phase completes in one cycle
  assign wr_stb = ce && s_reg.ap.valid && s_reg.ap.write;
  assign rd_stb = ce && s_reg.ap.valid && !s_reg.ap.write;
  assign idx = s_reg.ap.idx;

endmodule

// ===== hw/drs_top.sv
/*
  drs_top: register and status portion of a memory-to-memory transfer
  engine: pointers, byte count, status flags, control and interrupt.
  assumes: the read/write masters report beats and end-of-packet events
  as one-cycle pulses synchronous to CLK_SYS; AHB-Lite register access.
*/

// Function
// R1: five usable 32-bit registers reachable by software.
// R2: status at 0, read pointer 1, write pointer 2, count 3, control 6.
// R3: writing zero to status clears done, read-end, write-end, count-zero.
// R4: status readable anytime; reading changes no flag.
// R5: bit 0 done sets on end-of-packet or full length; sticky.
// R6: bit 1 busy is one exactly while a transfer runs; read-only. Busy stays one with RUN low after count hits zero without end-on-count.
// R7: bit 2 set when read-side end-of-packet ended the transfer.
// R8: bit 3 set when write-side end-of-packet ended the transfer.
// R9: bit 4 set when byte count decrements to zero.
// R10: software writes zeros to reserved status and control bits.
// R11: software does not write reserved offsets 4, 5, 7.
// R12: read start pointer holds first read location; width generated.
// R13: write start pointer holds first written location; width generated.
// R14: software programs count in bytes, aligned to transfer width.
// R15: count decrements on each written value, not on reads.
// R16: count saturates at zero.
// R17: count width is a generation parameter.
// R18: transfers run only with start bit set and count nonzero.
// R19: end-on-count bit ends transfer at zero; else only end-of-packet.
// R20: interrupt asserted while done and interrupt enable both one.
// R21: status writes leave the busy flag untouched.
// R22: pointers and count read back written values while idle.
module drs_top
#(
  parameter int RD_PTR_W = 32,
  parameter int WR_PTR_W = 32,
  parameter int COUNT_W = 32
)
(
  // clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CE,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic [1:0] HRESP,
  // data path events
  input wire logic WR_BEAT,
  input wire logic [4:0] BEAT_BYTES,
  input wire logic RD_EOP,
  input wire logic WR_EOP,
  // engine controls
  output logic RUN,
  output logic [RD_PTR_W-1:0] RD_START,
  output logic [WR_PTR_W-1:0] WR_START,
  output logic [drs_pkg::CT_W-1:0] CTRL,
  // interrupt
  output logic IRQ
);

  // ==========================================================
  // bus slave
  logic wr_stb;
  logic [2:0] idx;

  drs_ahb_slave u_slave
  (
    .clk(CLK_SYS),
    .nrst(NRST),
    .ce(CE),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hready(HREADY),
    .wr_stb(wr_stb),
    .rd_stb(),
    .idx(idx)
  );

  // ==========================================================
  // state
  typedef struct packed
  {
    drs_pkg::drs_state_t fsm;
    logic done;
    logic rd_pend;
    logic wr_pend;
    logic cnt_zero;
    logic [RD_PTR_W-1:0] rd_ptr;
    logic [WR_PTR_W-1:0] wr_ptr;
    logic [COUNT_W-1:0] count;
    logic [drs_pkg::CT_W-1:0] ctrl;
    logic [31:0] rdata;
  } drs_top_state_t;

  drs_top_state_t s_reg;
  drs_top_state_t s_next;
  drs_pkg::drs_evt_t evt;

  assign evt.wr_beat = WR_BEAT;
  assign evt.beat_bytes = BEAT_BYTES;
  assign evt.rd_eop = RD_EOP;
  assign evt.wr_eop = WR_EOP;

  // ==========================================================
  // helpers
  function automatic logic is_idx(input logic [2:0] a,
                                  input logic [2:0] b);
    is_idx = (a == b);
  endfunction

  function automatic logic [31:0] zext_rd(input logic [RD_PTR_W-1:0] v);
    logic [31:0] w;
    w = drs_pkg::ZERO_WORD;
    w[RD_PTR_W-1:0] = v;
    zext_rd = w;
  endfunction

  function automatic logic [31:0] zext_wr(input logic [WR_PTR_W-1:0] v);
    logic [31:0] w;
    w = drs_pkg::ZERO_WORD;
    w[WR_PTR_W-1:0] = v;
    zext_wr = w;
  endfunction

  function automatic logic [31:0] zext_cnt(input logic [COUNT_W-1:0] v);
    logic [31:0] w;
    w = drs_pkg::ZERO_WORD;
    w[COUNT_W-1:0] = v;
    zext_cnt = w;
  endfunction

  // R2: offset decode of one register word out of a state image
  function automatic logic [31:0] reg_word(input logic [2:0] a,
                                           input drs_top_state_t s);
    logic [31:0] w;
    w = drs_pkg::ZERO_WORD;
    case (a)
      // R4: reading status has no side effect
      drs_pkg::IDX_STATUS:
      begin
        w[drs_pkg::ST_DONE] = s.done;
        w[drs_pkg::ST_BUSY] = (s.fsm == drs_pkg::ST_RUN);
        w[drs_pkg::ST_RPEND] = s.rd_pend;
        w[drs_pkg::ST_WPEND] = s.wr_pend;
        w[drs_pkg::ST_CNTZ] = s.cnt_zero;
      end
      // R22: pointers and count read back as held
      drs_pkg::IDX_RD_PTR: w = zext_rd(s.rd_ptr);
      drs_pkg::IDX_WR_PTR: w = zext_wr(s.wr_ptr);
      drs_pkg::IDX_COUNT: w = zext_cnt(s.count);
      drs_pkg::IDX_CONTROL: w[drs_pkg::CT_W-1:0] = s.ctrl;
      default: w = drs_pkg::RSVD_READ;
    endcase
    reg_word = w;
  endfunction

  logic busy;
  logic rd_take;
  logic [COUNT_W-1:0] beat_w;
  logic [COUNT_W-1:0] cnt_dec;
  logic reach_zero;
  logic do_run;

  // R6: busy follows the run state
  assign busy = (s_reg.fsm == drs_pkg::ST_RUN);

  // read address phase accepted at this edge
  assign rd_take = HSEL && HREADY && !HWRITE &&
                   (HTRANS == drs_pkg::HTRANS_NONSEQ ||
                    HTRANS == drs_pkg::HTRANS_SEQ);

  // R18: only with start set and count nonzero
  assign do_run = busy && s_reg.ctrl[drs_pkg::CT_START] &&
                  (s_reg.count != '0);

  // R15: decrement only on write beats
  assign beat_w = COUNT_W'(evt.beat_bytes);
  // R16: saturate at zero
  assign cnt_dec = (s_reg.count > beat_w) ? s_reg.count - beat_w : '0;
  assign reach_zero = do_run && evt.wr_beat && (cnt_dec == '0);

  // ==========================================================
  // next state
  always_comb
  begin
    logic rd_end;
    logic wr_end;
    logic len_end;
    logic clr;
    rd_end = 1'b0;
    wr_end = 1'b0;
    len_end = 1'b0;
    clr = 1'b0;
    s_next = s_reg;
    s_next.rdata = drs_pkg::ZERO_WORD;

    // register writes
    if (wr_stb)
    begin
      case (idx)
        drs_pkg::IDX_STATUS:
        begin
          // R3: zero write clears the sticky flags; R21: busy untouched
          clr = (HWDATA == drs_pkg::ZERO_WORD);
        end
        // R12: read start pointer
        drs_pkg::IDX_RD_PTR: s_next.rd_ptr = HWDATA[RD_PTR_W-1:0];
        // R13: write start pointer
        drs_pkg::IDX_WR_PTR: s_next.wr_ptr = HWDATA[WR_PTR_W-1:0];
        // R17: count held at generated width
        drs_pkg::IDX_COUNT: s_next.count = HWDATA[COUNT_W-1:0];
        drs_pkg::IDX_CONTROL: s_next.ctrl = HWDATA[drs_pkg::CT_W-1:0];
        // reserved offsets: write ignored
        default: s_next.ctrl = s_reg.ctrl;
      endcase
    end
    if (clr)
    begin
      s_next.done = 1'b0;
      s_next.rd_pend = 1'b0;
      s_next.wr_pend = 1'b0;
      s_next.cnt_zero = 1'b0;
    end

    // count decrements; a same-cycle software write to count wins
    if (do_run && evt.wr_beat &&
        !(wr_stb && is_idx(idx, drs_pkg::IDX_COUNT)))
      s_next.count = cnt_dec;

    // R9: count-zero sets, winning over a clear
    if (reach_zero)
      s_next.cnt_zero = 1'b1;

    if (do_run)
    begin
      rd_end = evt.rd_eop && s_reg.ctrl[drs_pkg::CT_RD_EOP_EN];
      wr_end = evt.wr_eop && s_reg.ctrl[drs_pkg::CT_WR_EOP_EN];
      // R19: count reaching zero ends only with end-on-count set
      len_end = reach_zero && s_reg.ctrl[drs_pkg::CT_END_ON_CNT];
    end

    // R7: read-side end-of-packet cause
    if (rd_end)
      s_next.rd_pend = 1'b1;
    // R8: write-side end-of-packet cause
    if (wr_end)
      s_next.wr_pend = 1'b1;
    // R5: done sets on packet end or full length; set beats clear
    if (rd_end || wr_end || len_end)
      s_next.done = 1'b1;

    // transfer sequencing
    case (s_reg.fsm)
      drs_pkg::ST_IDLE:
      begin
        // R18: start bit with nonzero count and done clear launches a transfer
        if (s_reg.ctrl[drs_pkg::CT_START] && s_reg.count != '0 &&
            !s_reg.done)
          s_next.fsm = drs_pkg::ST_RUN;
      end
      drs_pkg::ST_RUN:
      begin
        // start cleared halts; otherwise end events finish the run
        if (!s_reg.ctrl[drs_pkg::CT_START] || rd_end || wr_end || len_end)
          s_next.fsm = drs_pkg::ST_IDLE;
      end
      default: s_next.fsm = drs_pkg::ST_IDLE;
    endcase

    // read data for the coming data phase, from the state it will show,
    // so a write or an event landing at the address edge is already seen
    if (rd_take)
      s_next.rdata = reg_word(HADDR[drs_pkg::ADDR_LSB +: drs_pkg::IDX_W],
                              s_next);
  end

  // ==========================================================
  // registers
  // R1: register file with five usable words
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      s_reg <= '0;
      s_reg.fsm <= drs_pkg::ST_IDLE;
    end
    else if (CE)
      s_reg <= s_next;
  end

  // ==========================================================
  // outputs
  // read data is loaded at the address edge and is zero outside a read
  // data phase, so the bus sees a flop and no decode path
  assign HRDATA = s_reg.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = drs_pkg::HRESP_OKAY;
  assign RUN = do_run;
  assign RD_START = s_reg.rd_ptr;
  assign WR_START = s_reg.wr_ptr;
  assign CTRL = s_reg.ctrl;

  // R20: interrupt from done gated by enable
  assign IRQ = s_reg.done && s_reg.ctrl[drs_pkg::CT_IRQ_EN];

endmodule

// ===== tb/drs_props.sv
/*
  drs_props: concurrent checks on the register block ports.
  assumes: bound into drs_top; one clock, NRST synchronous active low.
*/
module drs_props
#(
  parameter int RD_PTR_W = 32
)
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CE,
  // bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic [1:0] HRESP,
  // events and controls
  input wire logic RD_EOP,
  input wire logic WR_EOP,
  input wire logic RUN,
  input wire logic [RD_PTR_W-1:0] RD_START,
  input wire logic [drs_pkg::CT_W-1:0] CTRL,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);

  // ==========================================================
  // data phase tracker
  logic take;
  logic wdp_reg;
  logic rdp_reg;
  logic [2:0] idx_reg;
  logic [31:0] wd_reg;
  assign take = NRST && CE && HSEL && HREADY && HTRANS[1];
  always_ff @(posedge CLK_SYS)
  begin
    wdp_reg <= take && HWRITE;
    rdp_reg <= take && !HWRITE;
    idx_reg <= HADDR[4:2];
    wd_reg <= HWDATA;
  end

  // ==========================================================
  // properties
  okay_resp_a: assert property
    (HREADYOUT && HRESP == drs_pkg::HRESP_OKAY)
    else $error("bus answer not ready or not okay");
  ctrl_write_a: assert property
    (wdp_reg && idx_reg == drs_pkg::IDX_CONTROL |=>
     CTRL == wd_reg[drs_pkg::CT_W-1:0])
    else $error("control write not taken");
  rptr_write_a: assert property
    (wdp_reg && idx_reg == drs_pkg::IDX_RD_PTR |=>
     RD_START == wd_reg[RD_PTR_W-1:0])
    else $error("read pointer write not taken");
  rptr_hold_a: assert property
    (!(wdp_reg && idx_reg == drs_pkg::IDX_RD_PTR) |=> $stable(RD_START))
    else $error("read pointer changed without a write");
  busy_read_a: assert property
    (rdp_reg && idx_reg == drs_pkg::IDX_STATUS && RUN |->
     HRDATA[drs_pkg::ST_BUSY])
    else $error("busy flag low while running");
  rsvd_read_a: assert property
    (rdp_reg && idx_reg[2] && idx_reg != drs_pkg::IDX_CONTROL |->
     HRDATA == drs_pkg::RSVD_READ)
    else $error("reserved read not zero");
  run_start_a: assert property (RUN |-> CTRL[drs_pkg::CT_START])
    else $error("running with start bit clear");
  irq_enable_a: assert property (IRQ |-> CTRL[drs_pkg::CT_IRQ_EN])
    else $error("interrupt while disabled");
  wr_eop_stop_a: assert property
    (RUN && WR_EOP && CTRL[drs_pkg::CT_WR_EOP_EN] |=> !RUN)
    else $error("write end of packet did not stop");
  rd_eop_irq_a: assert property
    (RUN && RD_EOP && CTRL[drs_pkg::CT_RD_EOP_EN] &&
     CTRL[drs_pkg::CT_IRQ_EN] |=> IRQ && !RUN)
    else $error("read end of packet did not complete");
endmodule

bind drs_top drs_props #(.RD_PTR_W(RD_PTR_W)) i_props
(
  .CLK_SYS(CLK_SYS), .NRST(NRST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RD_EOP(RD_EOP),
  .WR_EOP(WR_EOP), .RUN(RUN), .RD_START(RD_START), .CTRL(CTRL), .IRQ(IRQ)
);

// ===== tb/drs_dpath_model.sv
/*
  drs_dpath_model: far-side data path giving beats and end-of-packet.
  assumes: the bench sets pacing and asks for end-of-packet pulses.
*/
module drs_dpath_model
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // commands
  input wire logic run,
  input wire logic [1:0] eop_req,
  input wire logic [4:0] bytes,
  input wire logic [1:0] gap,
  // events to the block
  output logic wr_beat,
  output logic [4:0] beat_bytes,
  output logic rd_eop,
  output logic wr_eop
);
  logic [1:0] cnt;
  logic fire;
  assign fire = nrst && run && cnt == gap;
  always_ff @(posedge clk)
  begin
    wr_beat <= fire;
    cnt <= fire || !run ? 2'h0 : cnt + 2'h1;
    // stale size lanes toggle so no old value lingers
    beat_bytes <= !nrst ? 5'h15 : fire ? bytes : ~beat_bytes;
    rd_eop <= nrst && run && eop_req[0];
    wr_eop <= nrst && run && eop_req[1];
  end
endmodule

// ===== tb/testbench.sv
/*
  testbench: register, completion and end-of-packet runs of drs_top.
  assumes: one AHB-Lite master, far-side model driven by the bench.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, nrst, hsel, hwrite, rd_dp, hreadyout, irq, run, ce;
  logic wr_beat, rd_eop, wr_eop;
  logic [31:0] haddr, hwdata, hrdata, rd_start, wr_start, v;
  logic [1:0] htrans, hresp, eop_req, gap;
  logic [4:0] beat_bytes, bytes;
  logic [12:0] ctrl;
  logic [31:0] expq[$];
  int n_fail = 0;
  int checked = 0;

  drs_top i_dut
  (
    .CLK_SYS(clk_sys), .NRST(nrst), .CE(ce), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .WR_BEAT(wr_beat),
    .BEAT_BYTES(beat_bytes), .RD_EOP(rd_eop), .WR_EOP(wr_eop), .RUN(run),
    .RD_START(rd_start), .WR_START(wr_start), .CTRL(ctrl), .IRQ(irq)
  );
  drs_dpath_model i_far
  (
    .clk(clk_sys), .nrst(nrst), .run(run), .eop_req(eop_req),
    .bytes(bytes), .gap(gap), .wr_beat(wr_beat),
    .beat_bytes(beat_bytes), .rd_eop(rd_eop), .wr_eop(wr_eop)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // checking and closing
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // bounded wait on hready or on the interrupt
  task automatic wait_for(input bit on_irq);
    int k;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while ((on_irq ? irq : hreadyout) !== 1'b1 && k < 600);
    if (k >= 600)
    begin
      n_fail++;
      give_verdict();
    end
  endtask

  // ==========================================================
  // single word transfer; a read notes its expected word
  task automatic bus(input logic wr, input logic [2:0] idx,
                     input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= drs_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {27'h000_0000, idx, 2'h0};
    wait_for(1'b0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0000_0000;
    rd_dp <= !wr;
    if (!wr)
      expq.push_back(d);
    wait_for(1'b0);
    rd_dp <= 1'b0;
  endtask

  always @(posedge clk_sys)
  begin
    if (rd_dp === 1'b1)
      check("hrdata", hrdata, expq.pop_front());
  end

  // ==========================================================
  // main sequence
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    rd_dp = 1'b0;
    eop_req = 2'h0;
    bytes = 5'h04;
    gap = 2'h0;
    void'($urandom(32'h0000_f753));
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++)
      bus(1'b0, 3'(i), 32'h0000_0000);
    // a write while the clock enable is low must leave no trace
    ce <= 1'b0;
    bus(1'b1, drs_pkg::IDX_RD_PTR, 32'hffff_ffff);
    ce <= 1'b1;
    bus(1'b0, drs_pkg::IDX_RD_PTR, 32'h0000_0000);
    $display("test reset values done");
    for (int i = 1; i < 4; i++)
    begin
      v = $urandom();
      bus(1'b1, 3'(i), v);
      bus(1'b0, 3'(i), v);
      if (i == 2)
        check("wr_start", wr_start, v);
    end
    v = $urandom() & 32'h0000_0ff7;
    bus(1'b1, drs_pkg::IDX_CONTROL, v);
    bus(1'b0, drs_pkg::IDX_CONTROL, v);
    // reserved offsets are never written; a nonzero status write is void
    bus(1'b1, drs_pkg::IDX_STATUS, 32'h0000_001f);
    bus(1'b0, drs_pkg::IDX_RSVD_A, 32'h0000_0000);
    bus(1'b1, drs_pkg::IDX_COUNT, 32'h0000_0000);
    bus(1'b1, drs_pkg::IDX_CONTROL, 32'h0000_0008);
    bus(1'b0, drs_pkg::IDX_STATUS, 32'h0000_0000);
    bus(1'b1, drs_pkg::IDX_CONTROL, 32'h0000_0000);
    $display("test readback done");
    for (int i = 0; i < 2; i++)
    begin
      bytes <= i ? 5'h08 : 5'h04;
      gap <= 2'($urandom());
      v = i ? 32'h0000_0004 : 32'($urandom_range(4, 1)) * 4;
      bus(1'b1, drs_pkg::IDX_COUNT, v);
      bus(1'b1, drs_pkg::IDX_CONTROL, 32'h0000_0098);
      wait_for(1'b1);
      bus(1'b0, drs_pkg::IDX_STATUS, 32'h0000_0011);
      bus(1'b0, drs_pkg::IDX_STATUS, 32'h0000_0011);
      bus(1'b0, drs_pkg::IDX_COUNT, 32'h0000_0000);
      bus(1'b1, drs_pkg::IDX_CONTROL, 32'h0000_0080);
      #1;
      check("irq", {31'h0, irq}, 32'h0000_0000);
      bus(1'b1, drs_pkg::IDX_STATUS, 32'h0000_0000);
      bus(1'b0, drs_pkg::IDX_STATUS, 32'h0000_0000);
    end
    $display("test count end done");
    bytes <= 5'h04;
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, drs_pkg::IDX_COUNT, 32'h0000_0100);
      bus(1'b1, drs_pkg::IDX_CONTROL, i ? 32'h0000_0058 : 32'h0000_0038);
      bus(1'b1, drs_pkg::IDX_STATUS, 32'h0000_0000);
      bus(1'b0, drs_pkg::IDX_STATUS, 32'h0000_0002);
      eop_req <= i ? 2'h2 : 2'h1;
      @(posedge clk_sys);
      eop_req <= 2'h0;
      v = i ? 32'h0000_0009 : 32'h0000_0005;
      bus(1'b0, drs_pkg::IDX_STATUS, v);
      #1;
      check("irq", {31'h0, irq}, 32'h0000_0001);
      bus(1'b1, drs_pkg::IDX_CONTROL, 32'h0000_0000);
      bus(1'b1, drs_pkg::IDX_STATUS, 32'h0000_0000);
    end
    $display("test end of packet done");
    give_verdict();
  end
endmodule
